// >>> verilog/cmpfc_pkg.sv
// cmpfc_pkg: register map, field positions and reset values for the
// comparator flag control block. assumes a 32-bit apb slave at 20 mhz.
package cmpfc_pkg;
   localparam int unsigned ADDR_W          = 8;
   // register byte offsets
   localparam logic [7:0]  CFG0_OFS        = 8'h00;
   localparam logic [7:0]  CFG1_OFS        = 8'h04;
   localparam logic [7:0]  PWR_AUX_OFS     = 8'h08;
   localparam logic [7:0]  MODE_OFS        = 8'h0c;
   // comparator configuration fields
   localparam int unsigned CFG_EN_BIT      = 0;
   localparam int unsigned CFG_NEG_REF_BIT = 1;
   localparam int unsigned CFG_OUT_BIT     = 2;
   localparam int unsigned CFG_IE_BIT      = 3;
   localparam int unsigned CFG_FLAG_BIT    = 4;
   // power control aux: comparator power-down at bit 5
   localparam int unsigned PWR_CMP_PD_BIT  = 5;
   // mode register: 0 run, 1 idle, 2 power-down, 3 total power-down
   localparam logic [1:0]  MODE_RUN        = 2'h0;
   localparam logic [1:0]  MODE_TOTAL_PD   = 2'h3;
   localparam logic [1:0]  MODE_RST        = 2'h0;
   localparam logic [31:0] RDATA_NONE      = 32'h0000_0000;
   // settle time after enable, for software reference only
   localparam int unsigned SETTLE_US       = 10;
   localparam int unsigned CLK_MHZ         = 20;
   localparam int unsigned SETTLE_CYC      = SETTLE_US * CLK_MHZ;
endpackage

// >>> verilog/cmpfc_chan.sv
// cmpfc_chan: one comparator channel: synchroniser, forced-high output,
// change flag with set-over-clear. assumes raw comparator level inputs.
`timescale 1ns/100ps
`default_nettype none
module cmpfc_chan
   import cmpfc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic cmp_pos_gt_pin,
   input  wire logic cmp_pos_gt_ref,
   input  wire logic enable,
   input  wire logic neg_sel_ref,
   input  wire logic flag_clr,
   output logic      out_bit_q,
   output logic      flag_q
);
   // both decisions are synchronised so the select never sees a raw
   // asynchronous level; costs two extra flops per channel
   logic pin_s1_q;
   logic pin_s2_q;
   logic ref_s1_q;
   logic ref_s2_q;
   wire  sel_s2;
   wire  out_d;
   wire  changed;

   assign sel_s2  = neg_sel_ref ? ref_s2_q : pin_s2_q;
   // disabled forces the output high; enabled follows the synced level
   assign out_d   = enable ? sel_s2 : 1'b1;
   assign changed = out_d != out_bit_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_s1_q  <= 1'b1;
         pin_s2_q  <= 1'b1;
         ref_s1_q  <= 1'b1;
         ref_s2_q  <= 1'b1;
         out_bit_q <= 1'b1;
         flag_q    <= 1'b0;
      end
      else
      begin
         pin_s1_q  <= cmp_pos_gt_pin;
         pin_s2_q  <= pin_s1_q;
         ref_s1_q  <= cmp_pos_gt_ref;
         ref_s2_q  <= ref_s1_q;
         out_bit_q <= out_d;
         // a change in the same cycle as the clear keeps the flag set
         flag_q    <= changed | (flag_q & ~flag_clr);
      end
   end
endmodule
`default_nettype wire

// >>> verilog/cmpfc_top.sv
// cmpfc_top: apb-reached control around the analog comparators.
// assumes comparator decisions arrive as asynchronous levels.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module cmpfc_top
   import cmpfc_pkg::*;
#(
   parameter int unsigned N_CMP = 2
)
(
   input  wire logic              REF_CLK,
   input  wire logic              RST,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic [N_CMP-1:0]  CMP_GT_PIN,
   input  wire logic [N_CMP-1:0]  CMP_GT_REF,
   output logic      [N_CMP-1:0]  CMP_EN,
   output logic      [N_CMP-1:0]  COMPARATOR_OUT_BIT,
   output logic                   CMP_IRQ,
   output logic                   WAKE_REQ
);
   logic [N_CMP-1:0] en_q;
   logic [N_CMP-1:0] negref_q;
   logic [N_CMP-1:0] ie_q;
   logic [N_CMP-1:0] out_bit;
   logic [N_CMP-1:0] comparator_change_flag;
   logic [N_CMP-1:0] flag_clr;
   logic [N_CMP-1:0] eff_en;
   logic             cmp_pd_q;
   logic [1:0]       mode_q;
   logic [31:0]      rdata_q;
   logic             ready_q;
   logic             slverr_q;
   logic             irq_q;
   logic             wake_q;

   wire access    = PSEL & PENABLE;
   wire wr        = access & PWRITE;
   // writes land at the edge that completes the transfer, pready high
   wire wr_done   = wr & ready_q;
   wire [N_CMP-1:0] forced_rise = ~eff_en & ~out_bit;
   wire hit_pwr   = PADDR == PWR_AUX_OFS;
   wire hit_mode  = PADDR == MODE_OFS;
   wire total_pd  = mode_q == MODE_TOTAL_PD;
   wire [N_CMP-1:0] hit_cfg;
   wire [N_CMP-1:0] irq_vec = comparator_change_flag & ie_q;
   wire             mapped  = hit_pwr | hit_mode | (|hit_cfg);
   logic [31:0]     rd_mux;

   genvar g;
   generate
      for (g = 0; g < N_CMP; g++)
      begin : g_ch
         assign hit_cfg[g] = PADDR == (CFG0_OFS + 8'(4 * g));
         // comparator off when disabled, bit 5 set, or total power-down
         assign eff_en[g]  = en_q[g] & ~cmp_pd_q & ~total_pd;
         // writing zero to the flag bit clears it
         assign flag_clr[g] = wr_done & hit_cfg[g]
                              & ~PWDATA[CFG_FLAG_BIT];
         cmpfc_chan u_chan
         (
            .clk            (REF_CLK),
            .rst            (RST),
            .cmp_pos_gt_pin (CMP_GT_PIN[g]),
            .cmp_pos_gt_ref (CMP_GT_REF[g]),
            .enable         (eff_en[g]),
            .neg_sel_ref    (negref_q[g]),
            .flag_clr       (flag_clr[g]),
            .out_bit_q      (out_bit[g]),
            .flag_q         (comparator_change_flag[g])
         );

         always_ff @(posedge REF_CLK)
         begin
            if (RST)
            begin
               en_q[g]     <= 1'b0;
               negref_q[g] <= 1'b0;
               ie_q[g]     <= 1'b0;
            end
            else if (wr_done & hit_cfg[g])
            begin
               en_q[g]     <= PWDATA[CFG_EN_BIT];
               negref_q[g] <= PWDATA[CFG_NEG_REF_BIT];
               ie_q[g]     <= PWDATA[CFG_IE_BIT];
            end
         end
      end
   endgenerate

   always_comb
   begin
      rd_mux = RDATA_NONE;
      if (hit_pwr)
         rd_mux[PWR_CMP_PD_BIT] = cmp_pd_q;
      if (hit_mode)
         rd_mux[1:0] = mode_q;
      for (int i = 0; i < N_CMP; i++)
      begin
         if (hit_cfg[i])
         begin
            rd_mux[CFG_EN_BIT]      = en_q[i];
            rd_mux[CFG_NEG_REF_BIT] = negref_q[i];
            rd_mux[CFG_OUT_BIT]     = out_bit[i];
            rd_mux[CFG_IE_BIT]      = ie_q[i];
            rd_mux[CFG_FLAG_BIT]    = comparator_change_flag[i];
         end
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         cmp_pd_q <= 1'b0;
         mode_q   <= MODE_RST;
         rdata_q  <= RDATA_NONE;
         ready_q  <= 1'b0;
         slverr_q <= 1'b0;
         irq_q    <= 1'b0;
         wake_q   <= 1'b0;
         CMP_EN   <= '0;
         COMPARATOR_OUT_BIT <= '1;
      end
      else
      begin
         // one wait state: answer in the cycle after penable rises
         ready_q  <= PSEL & PENABLE & ~ready_q;
         slverr_q <= PSEL & PENABLE & ~ready_q & ~mapped;
         if (PSEL & PENABLE & ~ready_q & ~PWRITE)
            rdata_q <= rd_mux;
         if (wr_done & hit_pwr)
            cmp_pd_q <= PWDATA[PWR_CMP_PD_BIT];
         if (wr_done & hit_mode)
            mode_q <= PWDATA[1:0];
         irq_q    <= |irq_vec;
         // wake only while idle or power-down, never in total power-down
         wake_q   <= (|irq_vec) & ~total_pd
                     & (mode_q != MODE_RUN);
         CMP_EN   <= eff_en;
         COMPARATOR_OUT_BIT <= out_bit;
      end
   end

   assign PRDATA  = rdata_q;
   assign PREADY  = ready_q;
   assign PSLVERR = slverr_q;
   assign CMP_IRQ = irq_q;
   assign WAKE_REQ = wake_q;

   property p_disabled_high;
      @(posedge REF_CLK) disable iff (RST)
      (CMP_EN == '0) [*3] |-> (COMPARATOR_OUT_BIT == '1);
   endproperty
   a_disabled_high: assert property (p_disabled_high)
      else $error("disabled comparator output not high");

   property p_change_sets_flag;
      @(posedge REF_CLK) disable iff (RST)
      (out_bit != $past(out_bit)) |->
         ((~comparator_change_flag & (out_bit ^ $past(out_bit))) == '0);
   endproperty
   a_change_sets_flag: assert property (p_change_sets_flag)
      else $error("output change did not set flag");

   property p_irq;
      @(posedge REF_CLK) disable iff (RST)
      (|(comparator_change_flag & ie_q)) |=> CMP_IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("flagged enabled comparator raised no interrupt");

   property p_total_pd;
      @(posedge REF_CLK) disable iff (RST)
      total_pd |=> (CMP_EN == '0) && !WAKE_REQ;
   endproperty
   a_total_pd: assert property (p_total_pd)
      else $error("comparator active in total power-down");

   property p_pd_bit;
      @(posedge REF_CLK) disable iff (RST)
      cmp_pd_q |=> (CMP_EN == '0);
   endproperty
   a_pd_bit: assert property (p_pd_bit)
      else $error("power-down bit did not disable comparator");

   property p_ready;
      @(posedge REF_CLK) disable iff (RST)
      (PSEL && PENABLE && !PREADY) |=> PREADY;
   endproperty
   a_ready: assert property (p_ready)
      else $error("apb access not answered in one wait state");

   property p_off_forces_high;
      @(posedge REF_CLK) disable iff (RST)
      1'b1 |=> ((~$past(eff_en) & ~out_bit) == '0);
   endproperty
   a_off_forces_high: assert property (p_off_forces_high)
      else $error("disabled comparator bit not forced high");

   property p_forced_rise_flags;
      @(posedge REF_CLK) disable iff (RST)
      (|forced_rise) |=>
         ((~comparator_change_flag & $past(forced_rise)) == '0);
   endproperty
   a_forced_rise_flags: assert property (p_forced_rise_flags)
      else $error("forced rise on disable did not set flag");

   property p_flag_clear;
      @(posedge REF_CLK) disable iff (RST)
      (|flag_clr) |=> ((comparator_change_flag & $past(flag_clr)
                        & ~(out_bit ^ $past(out_bit))) == '0);
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag not cleared by writing zero");

   property p_flag_holds;
      @(posedge REF_CLK) disable iff (RST)
      1'b1 |=> ((~comparator_change_flag & $past(comparator_change_flag)
                 & ~$past(flag_clr)) == '0);
   endproperty
   a_flag_holds: assert property (p_flag_holds)
      else $error("flag dropped without a clear");

   property p_no_spurious_flag;
      @(posedge REF_CLK) disable iff (RST)
      1'b1 |=> ((comparator_change_flag & ~$past(comparator_change_flag)
                 & ~(out_bit ^ $past(out_bit))) == '0);
   endproperty
   a_no_spurious_flag: assert property (p_no_spurious_flag)
      else $error("flag set without an output change");

   property p_irq_low;
      @(posedge REF_CLK) disable iff (RST)
      (irq_vec == '0) |=> !CMP_IRQ;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("interrupt without an enabled flag");

   property p_wake_sleep;
      @(posedge REF_CLK) disable iff (RST)
      ((|irq_vec) && !total_pd && (mode_q != MODE_RUN)) |=> WAKE_REQ;
   endproperty
   a_wake_sleep: assert property (p_wake_sleep)
      else $error("interrupt in sleep mode did not wake");

   property p_no_wake_run;
      @(posedge REF_CLK) disable iff (RST)
      (mode_q == MODE_RUN) |=> !WAKE_REQ;
   endproperty
   a_no_wake_run: assert property (p_no_wake_run)
      else $error("wake request while running");

   property p_en_follows;
      @(posedge REF_CLK) disable iff (RST)
      (!total_pd && !cmp_pd_q) |=> (CMP_EN == $past(en_q));
   endproperty
   a_en_follows: assert property (p_en_follows)
      else $error("comparator power does not follow its enable");

   property p_reset_state;
      @(posedge REF_CLK)
      RST |=> (CMP_EN == '0) && (COMPARATOR_OUT_BIT == '1) && !CMP_IRQ
              && !WAKE_REQ && (comparator_change_flag == '0) && (ie_q == '0);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("reset state wrong");

   property p_slverr;
      @(posedge REF_CLK) disable iff (RST)
      (PSEL && PENABLE && !PREADY && !mapped) |=> PREADY && PSLVERR;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("unmapped access without error response");

   property p_ready_pulse;
      @(posedge REF_CLK) disable iff (RST)
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held longer than one cycle");

   property p_read_negref;
      @(posedge REF_CLK) disable iff (RST)
      (PSEL && PENABLE && !PREADY && !PWRITE && (|hit_cfg)) |=>
         (PRDATA[CFG_NEG_REF_BIT] == (|($past(hit_cfg) & $past(negref_q))));
   endproperty
   a_read_negref: assert property (p_read_negref)
      else $error("input select read back wrong");

   property p_read_out;
      @(posedge REF_CLK) disable iff (RST)
      (PSEL && PENABLE && !PREADY && !PWRITE && (|hit_cfg)) |=>
         (PRDATA[CFG_OUT_BIT] == (|($past(hit_cfg) & $past(out_bit))));
   endproperty
   a_read_out: assert property (p_read_out)
      else $error("comparator bit read back wrong");
endmodule
`default_nettype wire

// >>> verif/cmpfc_analog_model.sv
// cmpfc_analog_model: behavioural analog front end of one comparator.
// assumes millivolt levels set by the bench between clock edges.
`timescale 1ns/100ps
`default_nettype none
module cmpfc_analog_model
#(
   parameter int REF_MV = 1230
)
(
   input  wire logic [15:0] pos_mv,
   input  wire logic [15:0] pin_mv,
   output logic             gt_pin,
   output logic             gt_ref
);
   // strict compare: equal levels read low, the harder boundary
   assign gt_pin = pos_mv > pin_mv;
   assign gt_ref = pos_mv > REF_MV;
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// tb_top: self-checking bench for the comparator flag control block.
// assumes two channels and an apb slave that answers with PREADY.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cmpfc_pkg::*;
   typedef struct packed {
      logic ch; logic rf; logic [15:0] p; logic [15:0] n; logic o;
   } cmpfc_row_s;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  padr = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] pos_mv = 32'h0;
   logic [31:0] pin_mv = 32'h0;
   logic [31:0] prd, rd;
   logic [1:0]  gt_pin, gt_ref, en, outb;
   logic        prdy, perr, irq, wake, er;
   logic [7:0]  a;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   // channel, reference select, positive, pin level, expected output
   cmpfc_row_s  rows [7] = '{'{0,0,900,500,1}, '{0,0,500,900,0},
      '{0,1,2000,0,1}, '{0,1,1000,0,0}, '{1,0,700,600,1},
      '{1,1,1230,0,0}, '{1,0,600,600,0}};
   always #25 clk = ~clk;
   cmpfc_analog_model u_ana [1:0] (
      .pos_mv(pos_mv),
      .pin_mv(pin_mv),
      .gt_pin(gt_pin),
      .gt_ref(gt_ref)
   );
   cmpfc_top #(.N_CMP(2)) dut (
      .REF_CLK(clk),
      .RST(rst),
      .PSEL(psel),
      .PENABLE(pen),
      .PWRITE(pwr),
      .PADDR(padr),
      .PWDATA(pwd),
      .PRDATA(prd),
      .PREADY(prdy),
      .PSLVERR(perr),
      .CMP_GT_PIN(gt_pin),
      .CMP_GT_REF(gt_ref),
      .CMP_EN(en),
      .COMPARATOR_OUT_BIT(outb),
      .CMP_IRQ(irq),
      .WAKE_REQ(wake)
   );
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until PREADY is sampled high, then released
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      padr <= ad;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         n_fail++;
         stop_test();
      end
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(outb, 2'b11);
      chk({irq, en}, 3'h0);
      apb(1'b0, CFG0_OFS, 32'h0);
      chk(rd, 32'h4);
      foreach (rows[i])
      begin
         a = rows[i].ch ? CFG1_OFS : CFG0_OFS;
         pos_mv[rows[i].ch*16 +: 16] <= rows[i].p;
         pin_mv[rows[i].ch*16 +: 16] <= rows[i].n;
         apb(1'b1, a, {30'h0, rows[i].rf, 1'b1});
         repeat (6) @(posedge clk);
         chk(outb[rows[i].ch], rows[i].o);
         apb(1'b0, a, 32'h0);
         chk(rd[CFG_OUT_BIT], rows[i].o);
      end
      pos_mv[15:0] <= 16'd100;
      pin_mv[15:0] <= 16'd500;
      apb(1'b1, CFG0_OFS, 32'h1);
      repeat (SETTLE_CYC) @(posedge clk);
      apb(1'b1, CFG0_OFS, 32'h9);
      chk(irq, 1'b0);
      apb(1'b1, MODE_OFS, 32'h1);
      pos_mv[15:0] <= 16'd900;
      repeat (6) @(posedge clk);
      apb(1'b0, CFG0_OFS, 32'h0);
      chk(rd[CFG_FLAG_BIT], 1'b1);
      chk({wake, irq, en[0]}, 3'h7);
      apb(1'b1, MODE_OFS, {30'h0, MODE_TOTAL_PD});
      repeat (6) @(posedge clk);
      chk({en[0], outb[0]}, 2'b01);
      apb(1'b1, MODE_OFS, 32'h0);
      apb(1'b1, PWR_AUX_OFS, 32'h20);
      repeat (6) @(posedge clk);
      chk({wake, irq, en[0], outb[0]}, 4'h5);
      apb(1'b1, PWR_AUX_OFS, 32'h0);
      pos_mv[15:0] <= 16'd100;
      apb(1'b1, CFG0_OFS, 32'h1);
      repeat (6) @(posedge clk);
      apb(1'b1, CFG0_OFS, 32'h1);
      apb(1'b1, CFG0_OFS, 32'h10);
      repeat (6) @(posedge clk);
      apb(1'b0, CFG0_OFS, 32'h0);
      chk({irq, outb[0], rd[4:0]}, 7'h34);
      apb(1'b1, CFG0_OFS, 32'h0);
      apb(1'b0, CFG0_OFS, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, 8'h10, 32'h0);
      chk(er, 1'b1);
      chk(rd, RDATA_NONE);
      // channel 1 in power-down: a rise wakes, then a reset mid-run
      apb(1'b1, CFG1_OFS, 32'h9);
      apb(1'b1, MODE_OFS, 32'h2);
      pos_mv[31:16] <= 16'd900;
      repeat (6) @(posedge clk);
      chk({wake, irq, outb[1]}, 3'h7);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({wake, irq, en, outb}, 6'h03);
      apb(1'b0, CFG1_OFS, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, MODE_OFS, 32'h0);
      chk(rd, {30'h0, MODE_RST});
      stop_test();
   end
endmodule
`default_nettype wire
